//--- upfm_pkg.sv
package upfm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned DEGLITCH_TIME_MS = 8;
  // Product is formed in 64 bits: milliseconds times 1e9 overflows 32 bits
  localparam int unsigned DEGLITCH_CYCLES =
    int'((longint'(DEGLITCH_TIME_MS) * 1000000000) / CLK_PERIOD_PS);
  localparam int unsigned HICCUP_OFF_TIME_MS = 118;
  localparam int unsigned HICCUP_OFF_CYCLES =
    int'((longint'(HICCUP_OFF_TIME_MS) * 1000000000) / CLK_PERIOD_PS);
  localparam int unsigned SHORT_CYCLE_COUNT = 128;
  localparam int unsigned OC_HOLD_TIME_MS = 8;
  localparam int unsigned OC_HOLD_CYCLES =
    int'((longint'(OC_HOLD_TIME_MS) * 1000000000) / CLK_PERIOD_PS);
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------------------------------
  // Fault source indices and advertisement codes
  // ----------------------------------------------------------------
  localparam int unsigned SRC_BUS_OV = 0;
  localparam int unsigned SRC_DATA_OV = 1;
  localparam int unsigned SRC_CC_OV = 2;
  localparam int unsigned SRC_VCONN_OC = 3;
  localparam int unsigned NUM_SRC = 4;
  localparam logic ADV_1A5 = 1'h0;
  localparam logic ADV_3A = 1'h1;
endpackage : upfm_pkg

//--- upfm_src_if.sv
// ----------------------------------------------------------------
// Raw and filtered fault levels between top and filter
// ----------------------------------------------------------------
interface upfm_src_if;
  logic raw;
  logic filt;
  modport top (output raw, input filt);
  modport flt (input raw, output filt);
endinterface : upfm_src_if

//--- upfm_deglitch.sv
// ----------------------------------------------------------------
// Two-way stability filter
// ----------------------------------------------------------------
module upfm_deglitch #(
  parameter int unsigned STABLE_CYCLES = upfm_pkg::DEGLITCH_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  upfm_src_if.flt src
);
  logic filt_q;
  logic [upfm_pkg::CNT_W-1:0] cnt_q;

  // Count while raw differs from output; flip once stable long enough
  always_ff @(posedge clk) begin
    if (reset) begin
      filt_q <= 1'b0;
      cnt_q <= '0;
    end else if (src.raw == filt_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= upfm_pkg::CNT_W'(STABLE_CYCLES - 1)) begin
      filt_q <= src.raw;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign src.filt = filt_q;
endmodule : upfm_deglitch

//--- upfm_hiccup.sv
// ----------------------------------------------------------------
// Buck hard-short hiccup controller
// ----------------------------------------------------------------
module upfm_hiccup #(
  parameter int unsigned SHORT_CYCLES = upfm_pkg::SHORT_CYCLE_COUNT,
  parameter int unsigned OFF_CYCLES = upfm_pkg::HICCUP_OFF_CYCLES,
  parameter int unsigned HOLD_CYCLES = upfm_pkg::OC_HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sw_cycle,
  input wire logic out_short,
  output logic buck_off,
  output logic oc_alarm
);
  logic [upfm_pkg::CNT_W-1:0] short_q;
  logic [upfm_pkg::CNT_W-1:0] off_q;
  logic [upfm_pkg::CNT_W-1:0] hold_q;
  logic trip;

  assign trip = sw_cycle && out_short && !buck_off &&
                short_q >= upfm_pkg::CNT_W'(SHORT_CYCLES - 1);

  // Consecutive short cycles; any clean cycle restarts the count
  always_ff @(posedge clk) begin
    if (reset || buck_off) begin
      short_q <= '0;
    end else if (sw_cycle) begin
      short_q <= out_short ? short_q + 1'b1 : '0;
    end
  end

  // Regulator held off for the hiccup time, then soft start again
  always_ff @(posedge clk) begin
    if (reset) begin
      buck_off <= 1'b0;
      off_q <= '0;
    end else if (trip) begin
      buck_off <= 1'b1;
      off_q <= upfm_pkg::CNT_W'(OFF_CYCLES - 1);
    end else if (buck_off) begin
      if (off_q == '0) begin
        buck_off <= 1'b0;
      end else begin
        off_q <= off_q - 1'b1;
      end
    end
  end

  // Alarm at trip, kept for the hold time
  always_ff @(posedge clk) begin
    if (reset) begin
      oc_alarm <= 1'b0;
      hold_q <= '0;
    end else if (trip) begin
      oc_alarm <= 1'b1;
      hold_q <= upfm_pkg::CNT_W'(HOLD_CYCLES - 1);
    end else if (oc_alarm) begin
      if (hold_q == '0) begin
        oc_alarm <= 1'b0;
      end else begin
        hold_q <= hold_q - 1'b1;
      end
    end
  end
endmodule : upfm_hiccup

//--- upfm_top.sv
// How it works
// - Mild overcurrent regulation never raises alarm
// - Hiccup trip raises alarm for hold time
// - Bus overvoltage: discharge on, gate off immediately
// - Overvoltage and VCONN alarms deglitched 8 ms
// - Data line overvoltage opens data switches immediately
// - CC overvoltage disconnects both CC lines immediately
// - VCONN overcurrent alarms, VCONN path stays on
// - Thermal warning raises flag without delay
// - Warning drops 3 A advertisement to 1.5 A
// - Thermal warning alone never raises alarm
// - Thermal shutdown stops buck, data, gate, bus
// - Thermal shutdown keeps thermal flag asserted
// - Alarm is active-low open drain
// - 128 short cycles: regulator off 118 ms
// - Bus overvoltage gone: gate on, alarm clears
module upfm_top #(
  parameter int unsigned DEGLITCH_CYCLES = upfm_pkg::DEGLITCH_CYCLES,
  parameter int unsigned SHORT_CYCLES = upfm_pkg::SHORT_CYCLE_COUNT,
  parameter int unsigned HICCUP_OFF_CYCLES = upfm_pkg::HICCUP_OFF_CYCLES,
  parameter int unsigned OC_HOLD_CYCLES = upfm_pkg::OC_HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_ov,
  input wire logic dplus_ov,
  input wire logic dminus_ov,
  input wire logic cc1_ov,
  input wire logic cc2_ov,
  input wire logic vconn_oc,
  input wire logic vconn_request,
  input wire logic current_limiting,
  input wire logic sw_cycle,
  input wire logic out_short,
  input wire logic thermal_alert_flag_level,
  input wire logic therm_sd_level,
  input wire logic adv_3a_request,
  input wire logic port_enable,
  output logic port_alarm_n_o,
  output logic port_alarm_n_oe_n,
  output logic thermal_alert_flag,
  output logic load_switch_gate,
  output logic bus_discharge,
  output logic bus_pull_low,
  output logic data_switch_closed,
  output logic cc_connected,
  output logic buck_enable,
  output logic vconn_enable,
  output logic adv_3a
);
  // ----------------------------------------------------------------
  // Deglitch filters, one per alarm source except the undeglitched hiccup alarm
  // ----------------------------------------------------------------
  upfm_src_if src [upfm_pkg::NUM_SRC] ();
  logic [upfm_pkg::NUM_SRC-1:0] filt;
  logic oc_alarm;
  logic hiccup_off;

  assign src[upfm_pkg::SRC_BUS_OV].raw = bus_ov;
  assign src[upfm_pkg::SRC_DATA_OV].raw = dplus_ov | dminus_ov;
  assign src[upfm_pkg::SRC_CC_OV].raw = cc1_ov | cc2_ov;
  assign src[upfm_pkg::SRC_VCONN_OC].raw = vconn_oc;

  for (genvar i = 0; i < upfm_pkg::NUM_SRC; i++) begin : g_flt
    upfm_deglitch #(
      .STABLE_CYCLES(DEGLITCH_CYCLES)
    ) u_flt (
      .clk(clk),
      .reset(reset),
      .src(src[i])
    );
    assign filt[i] = src[i].filt;
  end

  // ----------------------------------------------------------------
  // Hard-short hiccup
  // ----------------------------------------------------------------
  upfm_hiccup #(
    .SHORT_CYCLES(SHORT_CYCLES),
    .OFF_CYCLES(HICCUP_OFF_CYCLES),
    .HOLD_CYCLES(OC_HOLD_CYCLES)
  ) u_hiccup (
    .clk(clk),
    .reset(reset),
    .sw_cycle(sw_cycle),
    .out_short(out_short),
    .buck_off(hiccup_off),
    .oc_alarm(oc_alarm)
  );

  // ----------------------------------------------------------------
  // Alarm output
  // ----------------------------------------------------------------
  // Mild limiting and thermal warning are left out of the OR on purpose;
  // current_limiting is only a regulation status and feeds nothing here
  always_ff @(posedge clk) begin
    if (reset) begin
      port_alarm_n_o <= 1'b0;
      port_alarm_n_oe_n <= 1'b1;
    end else begin
      port_alarm_n_o <= 1'b0;
      port_alarm_n_oe_n <= !((|filt) | oc_alarm);
    end
  end

  // ----------------------------------------------------------------
  // Immediate protective actions, one registered stage
  // ----------------------------------------------------------------
  // Bus path: gate off on overvoltage or shutdown, back on when clear
  always_ff @(posedge clk) begin
    if (reset) begin
      load_switch_gate <= 1'b0;
      bus_discharge <= 1'b0;
      bus_pull_low <= 1'b0;
    end else begin
      load_switch_gate <= port_enable && !bus_ov && !therm_sd_level;
      bus_discharge <= bus_ov;
      bus_pull_low <= therm_sd_level;
    end
  end

  // Data and CC switches bypass the deglitch to protect the host side
  always_ff @(posedge clk) begin
    if (reset) begin
      data_switch_closed <= 1'b0;
      cc_connected <= 1'b0;
    end else begin
      data_switch_closed <= !(dplus_ov || dminus_ov) && !therm_sd_level;
      cc_connected <= !(cc1_ov || cc2_ov);
    end
  end

  // Buck stops on shutdown or during hiccup off time
  always_ff @(posedge clk) begin
    if (reset) begin
      buck_enable <= 1'b0;
    end else begin
      buck_enable <= port_enable && !therm_sd_level && !hiccup_off;
    end
  end

  // VCONN is deliberately not cut by its own overcurrent
  always_ff @(posedge clk) begin
    if (reset) begin
      vconn_enable <= 1'b0;
    end else begin
      vconn_enable <= vconn_request;
    end
  end

  // ----------------------------------------------------------------
  // Thermal flag and advertisement
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      thermal_alert_flag <= 1'b0;
      adv_3a <= upfm_pkg::ADV_1A5;
    end else begin
      thermal_alert_flag <= thermal_alert_flag_level || therm_sd_level;
      adv_3a <= (adv_3a_request && !thermal_alert_flag_level && !therm_sd_level)
                ? upfm_pkg::ADV_3A : upfm_pkg::ADV_1A5;
    end
  end
endmodule : upfm_top

//--- upfm_props.sv
// ----------------------------------------------------------------
// Port-level checks for the fault monitor
// ----------------------------------------------------------------
module upfm_props #(
  parameter int unsigned DEGLITCH_CYCLES = 8,
  parameter int unsigned OC_HOLD_CYCLES = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_ov,
  input wire logic dplus_ov,
  input wire logic dminus_ov,
  input wire logic cc1_ov,
  input wire logic cc2_ov,
  input wire logic vconn_oc,
  input wire logic vconn_request,
  input wire logic out_short,
  input wire logic thermal_alert_flag_level,
  input wire logic therm_sd_level,
  input wire logic port_alarm_n_o,
  input wire logic port_alarm_n_oe_n,
  input wire logic thermal_alert_flag,
  input wire logic load_switch_gate,
  input wire logic bus_discharge,
  input wire logic bus_pull_low,
  input wire logic data_switch_closed,
  input wire logic cc_connected,
  input wire logic buck_enable,
  input wire logic vconn_enable,
  input wire logic adv_3a
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] quiet_q;
  // Cycles with no raw fault; thermal warning deliberately not counted as a fault
  always_ff @(posedge clk) begin
    if (reset || bus_ov || dplus_ov || dminus_ov || cc1_ov || cc2_ov || vconn_oc
        || out_short) begin
      quiet_q <= 8'h0;
    end else if (quiet_q != 8'hff) begin
      quiet_q <= quiet_q + 8'h1;
    end
  end
  a_bus_gate_off: assert property (bus_ov |=> !load_switch_gate && bus_discharge)
    else $error("gate or discharge late on bus overvoltage");
  a_data_open: assert property ((dplus_ov || dminus_ov) |=> !data_switch_closed)
    else $error("data switches not opened");
  a_cc_cut: assert property ((cc1_ov || cc2_ov) |=> !cc_connected)
    else $error("cc lines not cut");
  a_warn_flag: assert property (thermal_alert_flag_level |=> thermal_alert_flag && !adv_3a)
    else $error("thermal flag or advertisement wrong");
  a_sd_actions: assert property (therm_sd_level |=>
    !buck_enable && !data_switch_closed && !load_switch_gate
    && bus_pull_low && thermal_alert_flag)
    else $error("shutdown actions missing");
  a_vconn_kept: assert property (vconn_oc && vconn_request && !therm_sd_level
    |=> vconn_enable)
    else $error("vconn path dropped on overcurrent");
  a_alarm_rise: assert property (vconn_oc [*8] |-> ##[1:3] !port_alarm_n_oe_n)
    else $error("alarm missing after stable overcurrent");
  a_alarm_quiet: assert property (quiet_q > DEGLITCH_CYCLES + OC_HOLD_CYCLES + 4
    |-> port_alarm_n_oe_n) else $error("alarm held with no fault");
  a_drive_low: assert property (port_alarm_n_o == 1'h0)
    else $error("open drain data not low");
  cover property (vconn_oc && !port_alarm_n_oe_n);
  cover property (therm_sd_level ##1 bus_pull_low);
  cover property (!buck_enable && !port_alarm_n_oe_n && !therm_sd_level);
endmodule : upfm_props

//--- upfm_host_model.sv
// ----------------------------------------------------------------
// Host side of the alarm pin
// ----------------------------------------------------------------
module upfm_host_model (
  input wire logic clk,
  input wire logic alarm_n_o,
  input wire logic alarm_n_oe_n,
  output logic fault_line,
  output logic [7:0] fault_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic line_q;
  logic [7:0] edges_q = 8'h0;
  // Pull-up sets the level whenever the pin is released
  assign fault_line = alarm_n_oe_n ? 1'h1 : alarm_n_o;
  assign fault_edges = edges_q;
  // Host counts every alarm assertion it sees
  always @(posedge clk) begin
    line_q <= fault_line;
    if (line_q === 1'h1 && fault_line === 1'h0) edges_q <= edges_q + 8'h1;
  end
endmodule : upfm_host_model

//--- upfm_top_tb.sv
module upfm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DG = 8;
  localparam int HOLD = 10;
  localparam int OFF = 20;
  logic clk = 1'h0, reset = 1'h1, bus_ov = 1'h0, dplus_ov = 1'h0, dminus_ov = 1'h0;
  logic cc1_ov = 1'h0, cc2_ov = 1'h0, vconn_oc = 1'h0, vconn_request = 1'h0;
  logic current_limiting = 1'h0, sw_cycle = 1'h0, out_short = 1'h0, thermal_alert_flag_level = 1'h0;
  logic therm_sd_level = 1'h0, adv_3a_request = 1'h0, port_enable = 1'h0;
  logic port_alarm_n_o, port_alarm_n_oe_n, thermal_alert_flag, load_switch_gate, bus_discharge;
  logic bus_pull_low, data_switch_closed, cc_connected, buck_enable, vconn_enable, adv_3a;
  logic fault_line;
  logic [7:0] fault_edges, n0;
  int err_total = 0, n_compared = 0;
  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  initial forever #2 clk = ~clk;
  upfm_top #(.DEGLITCH_CYCLES(DG), .SHORT_CYCLES(4), .HICCUP_OFF_CYCLES(OFF),
    .OC_HOLD_CYCLES(HOLD)) upfm_top_i (.clk(clk), .reset(reset), .bus_ov(bus_ov),
    .dplus_ov(dplus_ov), .dminus_ov(dminus_ov), .cc1_ov(cc1_ov), .cc2_ov(cc2_ov),
    .vconn_oc(vconn_oc), .vconn_request(vconn_request), .current_limiting(current_limiting),
    .sw_cycle(sw_cycle), .out_short(out_short), .thermal_alert_flag_level(thermal_alert_flag_level),
    .therm_sd_level(therm_sd_level), .adv_3a_request(adv_3a_request),
    .port_enable(port_enable), .port_alarm_n_o(port_alarm_n_o),
    .port_alarm_n_oe_n(port_alarm_n_oe_n), .thermal_alert_flag(thermal_alert_flag),
    .load_switch_gate(load_switch_gate), .bus_discharge(bus_discharge),
    .bus_pull_low(bus_pull_low), .data_switch_closed(data_switch_closed),
    .cc_connected(cc_connected), .buck_enable(buck_enable), .vconn_enable(vconn_enable),
    .adv_3a(adv_3a));
  upfm_host_model upfm_host_model_i (.clk(clk), .alarm_n_o(port_alarm_n_o),
    .alarm_n_oe_n(port_alarm_n_oe_n), .fault_line(fault_line), .fault_edges(fault_edges));
  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Step past the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Bounded wait for the host to see a level on the alarm pin
  task automatic wait_alarm(input logic lvl);
    int k;
    k = 0;
    // Step off the launching edge before the first look at the pin
    #1;
    while (fault_line !== lvl && k < 40) begin
      tick(1);
      k++;
    end
    check(fault_line, lvl);
    if (fault_line !== lvl) report_and_stop();
  endtask : wait_alarm
  // Main sequence; inputs change on the edge by non-blocking assignment
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    port_enable <= 1'h1;
    vconn_request <= 1'h1;
    adv_3a_request <= 1'h1;
    current_limiting <= 1'h1;
    tick(2 * DG);
    check(fault_line, 1'h1);
    check(adv_3a, 1'h1);
    @(posedge clk) bus_ov <= 1'h1;
    tick(1);
    check(load_switch_gate, 1'h0);
    check(bus_discharge, 1'h1);
    tick(DG - 3);
    check(fault_line, 1'h1);
    wait_alarm(1'h0);
    @(posedge clk) bus_ov <= 1'h0;
    wait_alarm(1'h1);
    check(load_switch_gate, 1'h1);
    // Short data-line glitch opens switches but never reaches the host
    n0 = fault_edges;
    @(posedge clk) dminus_ov <= 1'h1;
    tick(1);
    check(data_switch_closed, 1'h0);
    @(posedge clk) dminus_ov <= 1'h0;
    tick(3 * DG);
    check(fault_edges == n0, 1'h1);
    check(data_switch_closed, 1'h1);
    @(posedge clk) cc2_ov <= 1'h1;
    tick(1);
    check(cc_connected, 1'h0);
    @(posedge clk) cc2_ov <= 1'h0;
    vconn_oc <= 1'h1;
    wait_alarm(1'h0);
    tick(2 * DG);
    check(fault_line, 1'h0);
    check(vconn_enable, 1'h1);
    @(posedge clk) vconn_oc <= 1'h0;
    wait_alarm(1'h1);
    @(posedge clk) thermal_alert_flag_level <= 1'h1;
    tick(1);
    check(thermal_alert_flag, 1'h1);
    check(adv_3a, 1'h0);
    tick(2 * DG);
    check(fault_line, 1'h1);
    @(posedge clk) therm_sd_level <= 1'h1;
    thermal_alert_flag_level <= 1'h0;
    tick(1);
    check(buck_enable | data_switch_closed | load_switch_gate, 1'h0);
    check(bus_pull_low & thermal_alert_flag, 1'h1);
    @(posedge clk) therm_sd_level <= 1'h0;
    thermal_alert_flag_level <= 1'h0;
    out_short <= 1'h1;
    repeat (4) begin
      @(posedge clk) sw_cycle <= 1'h1;
      @(posedge clk) sw_cycle <= 1'h0;
    end
    wait_alarm(1'h0);
    check(buck_enable, 1'h0);
    @(posedge clk) out_short <= 1'h0;
    tick(HOLD - 4);
    check(fault_line, 1'h0);
    wait_alarm(1'h1);
    // Buck stays off OFF cycles, HOLD of them already spent under the alarm
    tick(OFF - HOLD - 1);
    check(buck_enable, 1'h0);
    tick(1);
    check(buck_enable, 1'h1);
    report_and_stop();
  end
endmodule : upfm_top_tb
bind upfm_top upfm_props #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES), .OC_HOLD_CYCLES(OC_HOLD_CYCLES))
  upfm_props_i (.clk(clk), .reset(reset), .bus_ov(bus_ov), .dplus_ov(dplus_ov),
  .dminus_ov(dminus_ov), .cc1_ov(cc1_ov), .cc2_ov(cc2_ov), .vconn_oc(vconn_oc),
  .vconn_request(vconn_request), .out_short(out_short), .thermal_alert_flag_level(thermal_alert_flag_level),
  .therm_sd_level(therm_sd_level), .port_alarm_n_o(port_alarm_n_o),
  .port_alarm_n_oe_n(port_alarm_n_oe_n), .thermal_alert_flag(thermal_alert_flag),
  .load_switch_gate(load_switch_gate), .bus_discharge(bus_discharge),
  .bus_pull_low(bus_pull_low), .data_switch_closed(data_switch_closed),
  .cc_connected(cc_connected), .buck_enable(buck_enable), .vconn_enable(vconn_enable),
  .adv_3a(adv_3a));
